// ==== hw/aicsp_ctrl_port.sv ====
// Two-wire register port of the amplifier: slave protocol, status, indicators and monitors
//
// What this block does
// - Undervoltage sets its indicator; reading the indicator register clears it.
// - Battery code is a 10-bit supply level, full scale 6.025V over 1023.
// - Die heat code reads as a two's complement value in degrees.
// - Current sense samples scale as sample over 32767 times 3.667A.
// - Voltage sense full scale is 11.79V internal or 16.5V external.
// - Output normalization voltage is 4.5V in receiver mode, 12V otherwise.
// - Receiver mode feeds the driver from supply with boost kept off.
// - Slave only, fast mode transfers up to 400 kHz.
// - Slave address is 01101 plus high and low select pins.
// - SDA sampled while SCL high; stray SDA movement aborts the transfer.
// - Bytes are eight bits MSB first, receiver acknowledges on ninth clock.
// - Write: address, register pointer, then high and low data bytes acknowledged.
// - Each further written word advances the register pointer by one.
// - Read: pointer write, restart, address with read bit, high then low byte.
// - Acknowledged low read byte advances pointer and returns next word.
// - Missing master acknowledge releases SDA and waits for stop.
// - Identity register returns a chip code; key 0x55aa restores configuration defaults.
// - Status bits 14,13,11,10,9,8 report supply and boost flags; 15,12 zero.
// - Status bits 7 to 0 report clip, watchdog, clock, current, heat, lock.
// - Indicator bits pair with status bits; undervoltage indicator set at power-on.
// - Any status change sets its indicator; an indicator register read clears all.
// - A masked indicator does not drive the interrupt pin; mask active high.
`timescale 1ns/1ps
`default_nettype none
`include "aicsp_defines.svh"
module aicsp_ctrl_port #(
  parameter logic [15:0] CHIP_ID = 16'h0a5c // Arbitrary identity value
) (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        sense_clk_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  input  wire logic        addr_select_low_pin_i,
  input  wire logic        addr_select_high_pin_i,
  input  wire logic        ext_vsense_sel_i,
  input  wire logic [15:0] sense_status_i,
  input  wire logic [9:0]  battery_level_code_i,
  input  wire logic [9:0]  die_heat_code_i,
  output logic             interrupt_out_pin_n_o,
  output logic             rcv_mode_o,
  output logic             boost_enable_o,
  output logic [15:0]      output_normalization_voltage_o,
  output logic [15:0]      vsense_full_scale_o,
  output logic [15:0]      isense_full_scale_o
);
  // Filter length rounds up, so no glitch shorter than the filter time can pass
  localparam logic [1:0] FILT_LAST = 2'(`AICSP_FILT_CYC - 1);
  localparam aicsp_pkg::aicsp_core_type CORE_RST = '{
    scl_s: 2'h3, sda_s: 2'h3, scl_f: 1'b1, sda_f: 1'b1,
    st: aicsp_pkg::AICSP_IDLE, kind: aicsp_pkg::AICSP_K_DEV,
    irq: `AICSP_IRQ_RST, mask: `AICSP_MASK_RST, ctrl: `AICSP_CTRL_RST,
    norm: `AICSP_NORM_SPK_MV, vfs: `AICSP_VFS_INT_MV, ifs: `AICSP_IFS_MA,
    sda_oe_n: 1'b1, int_n: 1'b1, boost_en: 1'b1, default: '0};

  aicsp_pkg::aicsp_core_type q, d;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic        wr;
  logic        ld;
  logic        rclr;
  logic        tx_go;
  logic [15:0] chg;

  aicsp_mon_if mon ();

  aicsp_sense_xfer u_xfer (
    .core_clk_i           (core_clk_i),
    .sense_clk_i          (sense_clk_i),
    .arst_n_i             (arst_n_i),
    .clk_en_i             (clk_en_i),
    .sense_status_i       (sense_status_i),
    .battery_level_code_i (battery_level_code_i),
    .die_heat_code_i      (die_heat_code_i),
    .mon                  (mon.src)
  );

  // Level accepted only after it has differed for the whole filter time
  function automatic logic [2:0] filt(input logic s, input logic f, input logic [1:0] c);
    if (s == f) begin
      filt = {f, 2'h0};
    end else if (c == FILT_LAST) begin
      filt = {s, 2'h0};
    end else begin
      filt = {f, c + 2'h1};
    end
  endfunction

  function automatic logic [15:0] rd_mux(input logic [7:0] a);
    case (a)
      `AICSP_OFS_ID:   rd_mux = CHIP_ID;
      `AICSP_OFS_ST:   rd_mux = q.st_prev;
      `AICSP_OFS_IRQ:  rd_mux = q.irq;
      `AICSP_OFS_MASK: rd_mux = q.mask;
      `AICSP_OFS_CTRL: rd_mux = q.ctrl;
      `AICSP_OFS_VBAT: rd_mux = {6'h00, mon.vbat};
      `AICSP_OFS_HEAT: rd_mux = {6'h00, mon.heat};
      default:         rd_mux = 16'h0000;
    endcase
  endfunction

  always_comb begin
    d     = q;
    wr    = 1'b0;
    ld    = 1'b0;
    rclr  = 1'b0;
    tx_go = 1'b0;
    d.scl_s = {q.scl_s[0], scl_i};
    d.sda_s = {q.sda_s[0], sda_i};
    d.adl_s = {q.adl_s[0], addr_select_low_pin_i};
    d.adh_s = {q.adh_s[0], addr_select_high_pin_i};
    d.ext_s = {q.ext_s[0], ext_vsense_sel_i};
    {d.scl_f, d.scl_c} = filt(q.scl_s[1], q.scl_f, q.scl_c);
    {d.sda_f, d.sda_c} = filt(q.sda_s[1], q.sda_f, q.sda_c);
    rise  = !q.scl_f && d.scl_f;
    fall  = q.scl_f && !d.scl_f;
    start = q.scl_f && d.scl_f && q.sda_f && !d.sda_f;
    stop  = q.scl_f && d.scl_f && !q.sda_f && d.sda_f;
    // SDA moving under high SCL ends whatever was in progress; a partial word is dropped
    if (stop) begin
      d.st       = aicsp_pkg::AICSP_IDLE;
      d.sda_oe_n = 1'b1;
    end else if (start) begin
      d.st       = aicsp_pkg::AICSP_RX;
      d.kind     = aicsp_pkg::AICSP_K_DEV;
      d.bcnt     = 4'h0;
      d.sda_oe_n = 1'b1;
    end else begin
      case (q.st)
        aicsp_pkg::AICSP_RX: begin
          if (rise) begin
            d.sh   = {q.sh[6:0], d.sda_f};
            d.bcnt = q.bcnt + 4'h1;
          end else if (fall && q.bcnt == 4'h8) begin
            d.st       = aicsp_pkg::AICSP_ACK;
            d.sda_oe_n = 1'b0;
            case (q.kind)
              aicsp_pkg::AICSP_K_DEV: begin
                if (q.sh[7:1] == {`AICSP_DEV_ADDR_HI, q.adh_s[1], q.adl_s[1]}) begin
                  d.rw   = q.sh[0];
                  d.kind = q.sh[0] ? aicsp_pkg::AICSP_K_HI : aicsp_pkg::AICSP_K_REG;
                end else begin
                  d.st       = aicsp_pkg::AICSP_WAIT;
                  d.sda_oe_n = 1'b1;
                end
              end
              aicsp_pkg::AICSP_K_REG: begin
                d.ptr  = q.sh;
                d.kind = aicsp_pkg::AICSP_K_HI;
              end
              aicsp_pkg::AICSP_K_HI: begin
                d.hi   = q.sh;
                d.kind = aicsp_pkg::AICSP_K_LO;
              end
              default: begin
                wr     = 1'b1;
                d.ptr  = q.ptr + 8'h01;
                d.kind = aicsp_pkg::AICSP_K_HI;
              end
            endcase
          end
        end
        aicsp_pkg::AICSP_ACK: begin
          if (fall) begin
            d.sda_oe_n = 1'b1;
            d.bcnt     = 4'h0;
            if (q.rw) begin
              d.st  = aicsp_pkg::AICSP_TX;
              ld    = 1'b1;
              tx_go = 1'b1;
            end else begin
              d.st = aicsp_pkg::AICSP_RX;
            end
          end
        end
        aicsp_pkg::AICSP_TX: begin
          if (fall) begin
            if (q.bcnt == 4'h7) begin
              d.st       = aicsp_pkg::AICSP_MACK;
              d.sda_oe_n = 1'b1;
            end else begin
              d.sh   = {q.sh[6:0], 1'b0};
              d.bcnt = q.bcnt + 4'h1;
              tx_go  = 1'b1;
            end
          end
        end
        aicsp_pkg::AICSP_MACK: begin
          if (rise && d.sda_f) begin
            d.st = aicsp_pkg::AICSP_WAIT;
          end else if (fall) begin
            d.st   = aicsp_pkg::AICSP_TX;
            d.bcnt = 4'h0;
            tx_go  = 1'b1;
            if (q.kind == aicsp_pkg::AICSP_K_HI) begin
              d.sh   = q.rword[7:0];
              d.kind = aicsp_pkg::AICSP_K_LO;
            end else begin
              d.ptr  = q.ptr + 8'h01;
              ld     = 1'b1;
              d.kind = aicsp_pkg::AICSP_K_HI;
            end
          end
        end
        default: ;
      endcase
    end
    // The whole word is latched at its first byte so both halves come from one moment
    if (ld) begin
      d.rword = rd_mux(d.ptr);
      d.sh    = d.rword[15:8];
      rclr    = (d.ptr == `AICSP_OFS_IRQ);
    end
    if (tx_go) begin
      d.sda_oe_n = d.sh[7];
    end
    if (wr) begin
      case (q.ptr)
        `AICSP_OFS_ID: begin
          if ({q.hi, q.sh} == `AICSP_SOFT_KEY) begin
            d.mask = `AICSP_MASK_RST;
            d.ctrl = `AICSP_CTRL_RST;
          end
        end
        `AICSP_OFS_MASK: d.mask = {q.hi, q.sh};
        `AICSP_OFS_CTRL: d.ctrl = {q.hi, q.sh};
        default: ;
      endcase
    end
    // A change landing in the clearing cycle still sets its indicator
    chg       = (mon.status & `AICSP_ST_IMPL) ^ q.st_prev;
    d.st_prev = mon.status & `AICSP_ST_IMPL;
    d.irq     = (rclr ? 16'h0000 : q.irq) | chg;
    d.int_n   = ~|(d.irq & ~d.mask);
    d.rcv     = d.ctrl[`AICSP_RCV_MODE_BIT];
    d.boost_en = !d.ctrl[`AICSP_RCV_MODE_BIT];
    d.norm    = d.ctrl[`AICSP_RCV_MODE_BIT] ? `AICSP_NORM_RCV_MV : `AICSP_NORM_SPK_MV;
    d.vfs     = q.ext_s[1] ? `AICSP_VFS_EXT_MV : `AICSP_VFS_INT_MV;
    d.ifs     = `AICSP_IFS_MA;
  end

  // Filter and sync add about four core cycles; at 400 kHz SCL that leaves ample margin
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= CORE_RST;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign sda_o                          = q.drv_lvl;
  assign sda_oe_n_o                     = q.sda_oe_n;
  assign interrupt_out_pin_n_o          = q.int_n;
  assign rcv_mode_o                     = q.rcv;
  assign boost_enable_o                 = q.boost_en;
  assign output_normalization_voltage_o = q.norm;
  assign vsense_full_scale_o            = q.vfs;
  assign isense_full_scale_o            = q.ifs;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_uv_set;
    clk_en_i && (mon.status[`AICSP_UNDERVOLTAGE_FLAG_BIT] != q.st_prev[`AICSP_UNDERVOLTAGE_FLAG_BIT])
      |=> q.irq[`AICSP_UNDERVOLTAGE_FLAG_BIT];
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("undervoltage change did not set its indicator");

  property p_pair_set;
    clk_en_i && (mon.status[`AICSP_PLL_LOCKED_FLAG_BIT] != q.st_prev[`AICSP_PLL_LOCKED_FLAG_BIT])
      |=> q.irq[`AICSP_PLL_LOCKED_FLAG_BIT] && !$past(rclr) || q.irq[`AICSP_PLL_LOCKED_FLAG_BIT];
  endproperty
  a_pair_set: assert property (p_pair_set) else $error("status change lost its indicator");

  property p_read_clear;
    clk_en_i && rclr && ((mon.status & `AICSP_ST_IMPL) == q.st_prev) |=> q.irq == 16'h0000;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("indicator read did not clear");

  property p_int_pin;
    ##1 (interrupt_out_pin_n_o == !(|(q.irq & ~q.mask)));
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("interrupt pin disagrees with masked indicators");

  property p_ack_drive;
    q.st == aicsp_pkg::AICSP_ACK |-> !sda_oe_n_o;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven");

  property p_addr_miss;
    clk_en_i && q.st == aicsp_pkg::AICSP_RX && q.kind == aicsp_pkg::AICSP_K_DEV && fall && q.bcnt == 4'h8
      && !start && !stop && q.sh[7:1] != {`AICSP_DEV_ADDR_HI, q.adh_s[1], q.adl_s[1]}
      |=> q.st == aicsp_pkg::AICSP_WAIT && sda_oe_n_o;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address was acknowledged");

  property p_wr_inc;
    clk_en_i && wr |=> q.ptr == $past(q.ptr) + 8'h01;
  endproperty
  a_wr_inc: assert property (p_wr_inc) else $error("write pointer did not advance");

  property p_nack_wait;
    clk_en_i && q.st == aicsp_pkg::AICSP_MACK && rise && d.sda_f |=> q.st == aicsp_pkg::AICSP_WAIT && sda_oe_n_o;
  endproperty
  a_nack_wait: assert property (p_nack_wait) else $error("no release after master nack");

  property p_soft_reset;
    clk_en_i && wr && q.ptr == `AICSP_OFS_ID && {q.hi, q.sh} == `AICSP_SOFT_KEY
      |=> q.mask == `AICSP_MASK_RST && q.ctrl == `AICSP_CTRL_RST;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("key write did not restore defaults");

  property p_stop_idle;
    clk_en_i && stop |=> q.st == aicsp_pkg::AICSP_IDLE && sda_oe_n_o;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not end the transfer");

  property p_rcv_mode;
    rcv_mode_o |-> !boost_enable_o && output_normalization_voltage_o == `AICSP_NORM_RCV_MV;
  endproperty
  a_rcv_mode: assert property (p_rcv_mode) else $error("receiver mode left boost on");

  c_write: cover property (clk_en_i && wr);
  c_read_next: cover property (clk_en_i && ld && q.st == aicsp_pkg::AICSP_MACK);
  c_nack: cover property (q.st == aicsp_pkg::AICSP_MACK ##1 q.st == aicsp_pkg::AICSP_WAIT);
  c_irq_read: cover property (clk_en_i && rclr && q.irq != 16'h0000);
endmodule
`default_nettype wire

// ==== hw/aicsp_defines.svh ====
// Register offsets, reset values, field positions and timing counts of the control port
`ifndef AICSP_DEFINES_SVH
`define AICSP_DEFINES_SVH
`define AICSP_OFS_ID        8'h00
`define AICSP_OFS_ST        8'h01
`define AICSP_OFS_IRQ       8'h02
`define AICSP_OFS_MASK      8'h03
`define AICSP_OFS_CTRL      8'h04
`define AICSP_OFS_VBAT      8'h21
`define AICSP_OFS_HEAT      8'h22
`define AICSP_SOFT_KEY      16'h55aa
`define AICSP_IRQ_RST       16'h4000
`define AICSP_MASK_RST      16'hffff
`define AICSP_CTRL_RST      16'h5307
`define AICSP_VBAT_RST      10'h263
`define AICSP_HEAT_RST      10'h019
`define AICSP_ST_IMPL       16'h6fff
`define AICSP_UNDERVOLTAGE_FLAG_BIT 14
`define AICSP_BOOST_ADAPTIVE_FLAG_BIT 13
`define AICSP_PLL_LOCKED_FLAG_BIT 0
`define AICSP_RCV_MODE_BIT  7
`define AICSP_DEV_ADDR_HI   5'h0d
`define AICSP_NORM_RCV_MV   16'h1194
`define AICSP_NORM_SPK_MV   16'h2ee0
`define AICSP_VFS_INT_MV    16'h2e0e
`define AICSP_VFS_EXT_MV    16'h4074
`define AICSP_IFS_MA        16'h0e53
`define AICSP_VBAT_FS_MV    16'h1789
`define AICSP_CLK_NS        25
`define AICSP_SCL_MAX_KHZ   400
`define AICSP_FILT_NS       50
`define AICSP_FILT_CYC      ((`AICSP_FILT_NS + `AICSP_CLK_NS - 1) / `AICSP_CLK_NS)
`endif

// ==== hw/aicsp_mon_if.sv ====
// Monitor values handed from the sense crossing to the port logic
`timescale 1ns/1ps
`default_nettype none
interface aicsp_mon_if;
  logic [15:0] status;
  logic [9:0]  vbat;
  logic [9:0]  heat;
  modport src (output status, vbat, heat);
  modport dst (input status, vbat, heat);
endinterface
`default_nettype wire

// ==== hw/aicsp_pkg.sv ====
// Types shared by the control port modules
`default_nettype none
package aicsp_pkg;
  typedef enum logic [2:0] {
    AICSP_IDLE = 3'h0,
    AICSP_RX   = 3'h1,
    AICSP_ACK  = 3'h2,
    AICSP_TX   = 3'h3,
    AICSP_MACK = 3'h4,
    AICSP_WAIT = 3'h5
  } aicsp_state_type;
  typedef enum logic [1:0] {
    AICSP_K_DEV = 2'h0,
    AICSP_K_REG = 2'h1,
    AICSP_K_HI  = 2'h2,
    AICSP_K_LO  = 2'h3
  } aicsp_kind_type;
  typedef struct packed {
    logic [1:0]      scl_s, sda_s, adl_s, adh_s, ext_s;
    logic            scl_f, sda_f;
    logic [1:0]      scl_c, sda_c;
    aicsp_state_type st;
    aicsp_kind_type  kind;
    logic [3:0]      bcnt;
    logic [7:0]      sh, ptr, hi;
    logic            rw;
    logic [15:0]     rword, st_prev, irq, mask, ctrl, norm, vfs, ifs;
    logic            sda_oe_n, drv_lvl, int_n, rcv, boost_en;
  } aicsp_core_type;
  typedef struct packed {
    logic [15:0] st;
    logic [9:0]  vb, ht;
    logic        req;
    logic [1:0]  ack_s;
  } aicsp_sdom_type;
  typedef struct packed {
    logic [1:0]  req_s;
    logic        ack;
    logic [15:0] st;
    logic [9:0]  vb, ht;
  } aicsp_cdom_type;
endpackage
`default_nettype wire

// ==== hw/aicsp_sense_xfer.sv ====
// Toggle handshake carrying status flags and monitor codes from the sense clock domain
`timescale 1ns/1ps
`default_nettype none
`include "aicsp_defines.svh"
module aicsp_sense_xfer (
  input  wire logic        core_clk_i,
  input  wire logic        sense_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic [15:0] sense_status_i,
  input  wire logic [9:0]  battery_level_code_i,
  input  wire logic [9:0]  die_heat_code_i,
  aicsp_mon_if.src         mon
);
  localparam aicsp_pkg::aicsp_sdom_type S_RST = '{vb: `AICSP_VBAT_RST, ht: `AICSP_HEAT_RST, default: '0};
  localparam aicsp_pkg::aicsp_cdom_type C_RST = '{vb: `AICSP_VBAT_RST, ht: `AICSP_HEAT_RST, default: '0};
  aicsp_pkg::aicsp_sdom_type s_q, s_d;
  aicsp_pkg::aicsp_cdom_type c_q, c_d;

  // Snapshot only moves once the core side has acknowledged, so it is stable when sampled
  always_comb begin
    s_d = s_q;
    s_d.ack_s = {s_q.ack_s[0], c_q.ack};
    if (s_q.ack_s[1] == s_q.req) begin
      s_d.st  = sense_status_i & `AICSP_ST_IMPL;
      s_d.vb  = battery_level_code_i;
      s_d.ht  = die_heat_code_i;
      s_d.req = ~s_q.req;
    end
  end

  always_ff @(posedge sense_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    c_d = c_q;
    c_d.req_s = {c_q.req_s[0], s_q.req};
    if (c_q.req_s[1] != c_q.ack) begin
      c_d.st  = s_q.st;
      c_d.vb  = s_q.vb;
      c_d.ht  = s_q.ht;
      c_d.ack = c_q.req_s[1];
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      c_q <= C_RST;
    end else if (clk_en_i) begin
      c_q <= c_d;
    end
  end

  assign mon.status = c_q.st;
  assign mon.vbat   = c_q.vb;
  assign mon.heat   = c_q.ht;

  property p_xfer_hold;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      (c_q.req_s[1] == c_q.ack) |=> $stable(c_q.vb) && $stable(c_q.st);
  endproperty
  a_xfer_hold: assert property (p_xfer_hold) else $error("monitor word changed without a handshake");
endmodule
`default_nettype wire

// ==== test/aicsp_host_model.sv ====
// Two-wire bus master model driving SCL and SDA toward the port
`timescale 1ns/1ps
`default_nettype none
module aicsp_host_model #(
  parameter int Q = 25
) (
  input  wire logic core_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // Idle lines rest high through the pull-ups; SCL stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Quarter bit; four of them give a 400 kHz bus clock at 25 ns
  task automatic q();
    repeat (Q) @(posedge core_clk_i);
    #1;
  endtask
  task automatic hstart();
    sda_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_o = 1'b0;
    q();
    scl_o = 1'b0;
    q();
  endtask
  task automatic hstop();
    sda_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_o = 1'b1;
    q();
  endtask
  // Data moves only while SCL is low and is sampled mid-high
  task automatic hbit(input logic b, output logic s);
    sda_o = b;
    q();
    scl_o = 1'b1;
    q();
    s = sda_i;
    q();
    scl_o = 1'b0;
    q();
  endtask
  // m is the ninth bit: 1 releases for a slave ack, 0 acks a read byte
  task automatic hbyte(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) hbit(d[i], r[i]);
    hbit(m, a);
    sda_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the two-wire register port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  typedef struct packed {logic wr; logic [7:0] ofs; logic [15:0] wd, exp;} aicsp_row_type;
  logic          core_clk, sense_clk, arst_n, scl, hsda, oe_n, dsda, adl, adh, ext, irq_n, rcv, bst, a, cen;
  logic [15:0]   sst, nv, vfs, ifs, w0, w1;
  logic [9:0]    vb, ht;
  logic [7:0]    r;
  wire           sda_w = hsda & (oe_n | dsda);
  int            mismatches, n_compared;
  aicsp_row_type rows[6] = '{'{1'b0, 8'h00, 16'h0000, 16'h0a5c}, '{1'b0, 8'h21, 16'h0000, 16'h01a5},
                             '{1'b0, 8'h22, 16'h0000, 16'h03d8}, '{1'b0, 8'h10, 16'h0000, 16'h0000},
                             '{1'b1, 8'h01, 16'hffff, 16'h0000}, '{1'b1, 8'h00, 16'h1234, 16'h0a5c}};
  aicsp_host_model host (.core_clk_i(core_clk), .sda_i(sda_w), .scl_o(scl), .sda_o(hsda));
  aicsp_ctrl_port uut (.core_clk_i(core_clk), .arst_n_i(arst_n), .clk_en_i(cen), .sense_clk_i(sense_clk),
    .scl_i(scl), .sda_i(sda_w), .sda_o(dsda), .sda_oe_n_o(oe_n), .addr_select_low_pin_i(adl),
    .addr_select_high_pin_i(adh), .ext_vsense_sel_i(ext), .sense_status_i(sst), .battery_level_code_i(vb),
    .die_heat_code_i(ht), .interrupt_out_pin_n_o(irq_n), .rcv_mode_o(rcv), .boost_enable_o(bst),
    .output_normalization_voltage_o(nv), .vsense_full_scale_o(vfs), .isense_full_scale_o(ifs));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Sense clock offset so its edges never line up with a rising core clock edge
  initial begin
    sense_clk = 1'b0;
    #7;
    forever #24 sense_clk = ~sense_clk;
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic dev(input logic rd);
    host.hbyte({5'h0d, adh, adl, rd}, 1'b1, r, a);
    `CHK("dev_ack", 1'b0, a)
  endtask
  task automatic set_ptr(input logic [7:0] ofs);
    host.hstart();
    dev(1'b0);
    host.hbyte(ofs, 1'b1, r, a);
    `CHK("ptr_ack", 1'b0, a)
  endtask
  task automatic reg_wr(input logic [7:0] ofs, input logic [15:0] d0, input logic [15:0] d1, input int n);
    logic [31:0] dd;
    dd = {d0, d1};
    set_ptr(ofs);
    for (int k = 0; k < 2 * n; k++) begin
      host.hbyte(dd[31 - 8 * k -: 8], 1'b1, r, a);
      `CHK("data_ack", 1'b0, a)
    end
    host.hstop();
  endtask
  task automatic reg_rd(input logic [7:0] ofs, input int n, output logic [15:0] x0, output logic [15:0] x1);
    logic [31:0] dd;
    dd = '0;
    set_ptr(ofs);
    host.hstart();
    dev(1'b1);
    for (int k = 0; k < 2 * n; k++) begin
      host.hbyte(8'hff, k == 2 * n - 1, r, a);
      dd[31 - 8 * k -: 8] = r;
    end
    host.hstop();
    x0 = dd[31:16];
    x1 = dd[15:0];
  endtask
  initial begin
    // The tests need about 97,000 cycles; a hang is cut off at 100,000
    repeat (100000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end
  initial begin
    {arst_n, adl, adh, ext} = 4'h0;
    cen = 1'b1;
    sst = 16'h0000;
    // Differs from the reset value so the row read proves the crossing moved it
    vb = 10'h1a5;
    ht = 10'h3d8;
    repeat (5) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    `CHK("ifs", 16'h0e53, ifs)
    `CHK("norm", 16'h2ee0, nv)
    `CHK("boost", 1'b1, bst)
    `CHK("irq_pin", 1'b1, irq_n)
    ext = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    `CHK("vfs", 16'h4074, vfs)
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      if (rows[i].wr) reg_wr(rows[i].ofs, rows[i].wd, 16'h0000, 1);
      reg_rd(rows[i].ofs, 1, w0, w1);
      `CHK("row", rows[i].exp, w0)
    end
    $display("row tests done");
    reg_wr(8'h03, 16'hbfff, 16'h5387, 2);
    reg_rd(8'h03, 2, w0, w1);
    `CHK("mask", 16'hbfff, w0)
    `CHK("ctrl", 16'h5387, w1)
    `CHK("rcv", 1'b1, rcv)
    `CHK("boost_off", 1'b0, bst)
    `CHK("norm_rcv", 16'h1194, nv)
    `CHK("irq_low", 1'b0, irq_n)
    reg_rd(8'h02, 1, w0, w1);
    `CHK("power_on_ind", 16'h4000, w0)
    `CHK("irq_clear", 1'b1, irq_n)
    $display("burst test done");
    // Bits 15 and 12 of the sense word must not reach status or indicators
    sst = 16'hd401;
    repeat (40) @(posedge core_clk);
    #1;
    `CHK("uv_pin", 1'b0, irq_n)
    reg_rd(8'h01, 2, w0, w1);
    `CHK("status", 16'h4401, w0)
    `CHK("ind", 16'h4401, w1)
    reg_rd(8'h02, 1, w0, w1);
    `CHK("ind_cleared", 16'h0000, w0)
    $display("status test done");
    reg_wr(8'h00, 16'h55aa, 16'h0000, 1);
    reg_rd(8'h03, 2, w0, w1);
    `CHK("mask_dflt", 16'hffff, w0)
    `CHK("ctrl_dflt", 16'h5307, w1)
    $display("soft reset test done");
    for (int p = 0; p < 4; p++) begin
      {adh, adl} = p[1:0];
      repeat (10) @(posedge core_clk);
      #1;
      host.hstart();
      host.hbyte({5'h0d, p[1:0] + 2'h1, 1'b0}, 1'b1, r, a);
      `CHK("foreign_nack", 1'b1, a)
      host.hstart();
      dev(1'b0);
      host.hstop();
    end
    $display("address test done");
    set_ptr(8'h00);
    host.hstart();
    dev(1'b1);
    host.hbyte(8'hff, 1'b1, r, a);
    `CHK("id_hi", 8'h0a, r)
    host.hbyte(8'hff, 1'b1, r, a);
    `CHK("released", 8'hff, r)
    host.hstop();
    // Start in mid-word: the half-received word must be dropped
    set_ptr(8'h03);
    host.hbyte(8'h12, 1'b1, r, a);
    host.hstart();
    // Taken as a foreign address after the start; as a low byte it would write 0x1234
    host.hbyte(8'h34, 1'b1, r, a);
    `CHK("abort_nack", 1'b1, a)
    host.hstop();
    reg_rd(8'h03, 1, w0, w1);
    `CHK("abort", 16'hffff, w0)
    $display("nack and abort tests done");
    // Enable low must hold the core side, pin synchronisers included
    cen = 1'b0;
    ext = 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
    `CHK("frozen_vfs", 16'h4074, vfs)
    cen = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    `CHK("vfs_int", 16'h2e0e, vfs)
    $display("clock enable test done");
    end_sim();
  end
endmodule
`default_nettype wire
